// ---- hdl/pos_framer.v ----
// Our own choices: the strobed register port and the address map.
`timescale 1ns/100ps
// How it works
// [R1] A telegram is six segments, 88 bits, eleven bytes; A..C then D..F.
// [R2] Byte 0 counter, status nibble next, then 20-bit millimetre position.
// [R3] Position is followed by 32-bit checksum, 16-bit info word, 8-bit fine offset.
// [R4] In single-channel mode only the first three segments are sent; the code sends only three bytes, without position bits 7..0.
// [R5] Counter rises by one per telegram and wraps 255 to 0.
// [R6] Status flags sit in the second byte and describe this telegram's position.
// [R7] Bit 4 set when one channel failed and the position was extrapolated.
// [R8] Bit 5 set when the tape is missing or faulty.
// [R9] Bit 6 set once extrapolation was disabled for too many reading errors.
// [R10] Bit 7 set when under-voltage forced single-channel operation.
// [R11] Odd counter values invert all four status flags before sending.
// [R12] Coarse position goes out high byte first.
// [R13] Only 18 position bits and 4 offset bits used; upper bits zero.
// [R14] Receiver should mask the unused upper bits.
// [R15] CRC32, Ethernet generator, over counter, status, position, MSB first.
// [R16] CRC register preset to all ones each telegram.
// [R17] CRC computed reflected, complemented, sent high byte first.
// [R18] Receiver trusts the data only with a matching checksum in dual mode.
// [R19] Info word picked by counter value and sent high byte first.
// [R20] Counts 0-7 carry code CRC, serial, error registers; 8-127 carry zero.
// [R21] Channel A voltages at 174/175, errors at 180/181, uptime at 182/183.
// [R22] Channel B voltages at 238/239, errors at 244/245, uptime at 246/247.
// [R23] Line runs 115200 bit/s, 8 data bits, no parity, one stop bit.
// [R24] Bytes go out in segment order, each field high byte first.
`include "pos_framer_defs.vh"

module pos_framer #(
   parameter CLK_HZ = `FR_CLK_HZ,
   parameter BAUD = `FR_BAUD
) (
   // Clock, reset, enable
   input wire SYS_CLK_I,
   input wire RESETN_I,
   input wire CE_I,
   // Telegram trigger and position data
   input wire SEND_I,
   input wire [19:0] POS_I,
   input wire [7:0] FINE_I,
   // Status conditions
   input wire EXTRAP_I,
   input wire TAPE_BAD_I,
   input wire NOEXTRAP_I,
   input wire UNDERVOLT_I,
   // Diagnostic words
   input wire [31:0] CODE_CRC_I,
   input wire [31:0] SERIAL_I,
   input wire [31:0] ERR_A_I,
   input wire [31:0] ERR_B_I,
   input wire [15:0] VMIN_A_I,
   input wire [15:0] VMAX_A_I,
   input wire [31:0] ERRS_A_I,
   input wire [31:0] UPTIME_A_I,
   input wire [15:0] VMIN_B_I,
   input wire [15:0] VMAX_B_I,
   input wire [31:0] ERRS_B_I,
   input wire [31:0] UPTIME_B_I,
   // Register port
   input wire [3:0] ADDR_I,
   input wire [31:0] WDATA_I,
   input wire WR_I,
   input wire RD_I,
   output reg [31:0] RDATA_O,
   // Serial line
   output reg TXD_O,
   output reg TX_EN_O,
   output reg BUSY_O,
   output reg DONE_O
);

   localparam integer BIT_DIV = CLK_HZ / BAUD;
   localparam [8:0] BIT_LAST = BIT_DIV[8:0] - 9'h001;
   localparam ST_IDLE = 1'b0;
   localparam ST_SEND = 1'b1;

   // Reflected CRC32 over 32 data bits, fed MSB first
   function [31:0] crc32_rev;
      input [31:0] data;
      integer i;
      reg [31:0] c;
      reg fb;
      begin
         c = `FR_CRC_PRESET; // [R16]
         for (i = 31; i >= 0; i = i - 1) begin
            fb = c[0] ^ data[i];
            c = {1'b0, c[31:1]} ^ (fb ? `FR_CRC_POLY_REV : 32'h00000000); // [R17]
         end
         crc32_rev = c;
      end
   endfunction

   // One UART symbol: data byte with stop bits above it, shifted out LSB first
   function [9:0] load_byte;
      input [7:0] b;
      begin
         load_byte = {2'b11, b};
      end
   endfunction

   // Framer state and shift registers with their next values
   reg state_r;
   reg state_nxt;
   reg [7:0] cnt_r;
   reg [7:0] cnt_nxt;
   reg [79:0] frame_r;
   reg [79:0] frame_nxt;
   reg [9:0] tx_sr_r;
   reg [9:0] tx_sr_nxt;
   reg [3:0] bits_r;
   reg [3:0] bits_nxt;
   reg [3:0] bytes_r;
   reg [3:0] bytes_nxt;
   reg [8:0] baud_r;
   reg [8:0] baud_nxt;
   reg txd_nxt;
   reg tx_en_nxt;
   reg busy_nxt;
   reg done_nxt;

   // Register port state with next values
   reg [1:0] ctrl_r;
   reg [1:0] ctrl_nxt;
   reg [31:0] rdata_nxt;

   // Diagnostic word picked for this telegram
   reg [15:0] info_w;

   wire single = UNDERVOLT_I | ctrl_r[`FR_CTRL_SINGLE];
   wire [3:0] flags;
   wire [3:0] stat_nib;
   wire [19:0] pos_used;
   wire [7:0] fine_used;
   wire [31:0] crc_in;
   wire [31:0] crc_out;
   wire [87:0] frame;
   wire start;

   // Flags from bit 7 down to bit 4; on the line bit 4 goes first
   assign flags[`FR_ST_SINGLE - 4] = single; // [R10]
   assign flags[`FR_ST_NOEXTRAP - 4] = NOEXTRAP_I; // [R9]
   assign flags[`FR_ST_TAPE - 4] = TAPE_BAD_I; // [R8]
   assign flags[`FR_ST_EXTRAP - 4] = EXTRAP_I; // [R7]
   assign stat_nib = flags ^ {4{cnt_r[0]}}; // [R11]

   // Unused upper bits forced to zero
   assign pos_used = {2'b00, POS_I[`FR_POS_USED-1:0]}; // [R13]
   assign fine_used = {4'h0, FINE_I[`FR_FINE_USED-1:0]}; // [R13]

   // Counter, status and position share one 32-bit word
   assign crc_in = {cnt_r, stat_nib, pos_used}; // [R2] [R6] [R15]
   assign crc_out = ~crc32_rev(crc_in); // [R17]

   // Eleven symbols in segment order, each field high byte first
   wire [7:0] sym_0 = cnt_r; // [R2]
   wire [7:0] sym_1 = {stat_nib, pos_used[19:16]}; // [R6]
   wire [7:0] sym_2 = pos_used[15:8]; // [R12]
   wire [7:0] sym_3 = pos_used[7:0]; // [R12]
   wire [7:0] sym_4 = crc_out[31:24]; // [R17]
   wire [7:0] sym_5 = crc_out[23:16];
   wire [7:0] sym_6 = crc_out[15:8];
   wire [7:0] sym_7 = crc_out[7:0];
   wire [7:0] sym_8 = info_w[15:8]; // [R19]
   wire [7:0] sym_9 = info_w[7:0];
   wire [7:0] sym_10 = fine_used; // [R3]

   // Whole telegram, first byte in the top bits
   assign frame = {sym_0, sym_1, sym_2, sym_3, sym_4, sym_5, sym_6, sym_7, // [R1] [R24]
                   sym_8, sym_9, sym_10};

   assign start = SEND_I & ctrl_r[`FR_CTRL_EN] & (state_r == ST_IDLE);

   // Info word chosen by counter value
   always @* begin
      case (cnt_r) // [R19]
         8'h00: info_w = CODE_CRC_I[31:16]; // [R20]
         8'h01: info_w = CODE_CRC_I[15:0];
         8'h02: info_w = SERIAL_I[31:16];
         8'h03: info_w = SERIAL_I[15:0];
         8'h04: info_w = ERR_A_I[31:16];
         8'h05: info_w = ERR_A_I[15:0];
         8'h06: info_w = ERR_B_I[31:16];
         8'h07: info_w = ERR_B_I[15:0];
         `FR_AI_VMIN_A: info_w = VMIN_A_I; // [R21]
         `FR_AI_VMAX_A: info_w = VMAX_A_I;
         `FR_AI_ERRS_A: info_w = ERRS_A_I[31:16];
         `FR_AI_ERRS_A + 8'h01: info_w = ERRS_A_I[15:0];
         `FR_AI_OPT_A: info_w = UPTIME_A_I[31:16];
         `FR_AI_OPT_A + 8'h01: info_w = UPTIME_A_I[15:0];
         `FR_AI_VMIN_B: info_w = VMIN_B_I; // [R22]
         `FR_AI_VMAX_B: info_w = VMAX_B_I;
         `FR_AI_ERRS_B: info_w = ERRS_B_I[31:16];
         `FR_AI_ERRS_B + 8'h01: info_w = ERRS_B_I[15:0];
         `FR_AI_OPT_B: info_w = UPTIME_B_I[31:16];
         `FR_AI_OPT_B + 8'h01: info_w = UPTIME_B_I[15:0];
         default: info_w = 16'h0000; // [R20]
      endcase
   end

   // Register port next values: control write, read data for one cycle only
   always @* begin
      ctrl_nxt = ctrl_r;
      rdata_nxt = 32'h00000000;
      if (WR_I && ADDR_I == `FR_REG_CTRL) begin
         ctrl_nxt = WDATA_I[1:0];
      end
      if (RD_I) begin
         case (ADDR_I)
            `FR_REG_CTRL: rdata_nxt = {30'h00000000, ctrl_r};
            `FR_REG_STAT: rdata_nxt = {16'h0000, cnt_r, 6'h00, single, state_r};
            default: rdata_nxt = 32'h00000000;
         endcase
      end
   end

   // Register port flops, frozen while the clock enable is low
   always @(posedge SYS_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         ctrl_r <= `FR_CTRL_RST;
         RDATA_O <= 32'h00000000;
      end else if (CE_I) begin
         ctrl_r <= ctrl_nxt;
         RDATA_O <= rdata_nxt;
      end
   end

   // Framer next state: start bit, data bits LSB first, stop bit, next byte
   always @* begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      frame_nxt = frame_r;
      tx_sr_nxt = tx_sr_r;
      bits_nxt = bits_r;
      bytes_nxt = bytes_r;
      baud_nxt = baud_r;
      txd_nxt = TXD_O;
      tx_en_nxt = TX_EN_O;
      busy_nxt = BUSY_O;
      done_nxt = 1'b0;
      case (state_r)
         ST_IDLE: begin
            if (start) begin
               // Inputs are captured here so the whole telegram describes one instant
               state_nxt = ST_SEND;
               frame_nxt = frame[79:0];
               tx_sr_nxt = load_byte(frame[87:80]);
               txd_nxt = 1'b0; // Start bit
               bits_nxt = 4'h9;
               baud_nxt = BIT_LAST; // [R23]
               bytes_nxt = single ? `FR_BYTES_SINGLE - 4'h1 : `FR_BYTES_DUAL - 4'h1; // [R4]
               cnt_nxt = cnt_r + 8'h01; // [R5]
               tx_en_nxt = 1'b1;
               busy_nxt = 1'b1;
            end
         end
         ST_SEND: begin
            if (baud_r != 9'h000) begin
               baud_nxt = baud_r - 9'h001;
            end else begin
               baud_nxt = BIT_LAST;
               if (bits_r != 4'h0) begin
                  // Data bits then stop bit
                  txd_nxt = tx_sr_r[0]; // [R23]
                  tx_sr_nxt = {1'b1, tx_sr_r[9:1]};
                  bits_nxt = bits_r - 4'h1;
               end else if (bytes_r != 4'h0) begin
                  // Next byte in segment order, no idle gap between symbols
                  txd_nxt = 1'b0;
                  tx_sr_nxt = load_byte(frame_r[79:72]); // [R24]
                  frame_nxt = {frame_r[71:0], 8'h00};
                  bits_nxt = 4'h9;
                  bytes_nxt = bytes_r - 4'h1;
               end else begin
                  // Last stop bit served: release the line driver
                  state_nxt = ST_IDLE;
                  txd_nxt = 1'b1;
                  tx_en_nxt = 1'b0;
                  busy_nxt = 1'b0;
                  done_nxt = 1'b1;
               end
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   // Framer flops; outputs come straight from here
   always @(posedge SYS_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         state_r <= ST_IDLE;
         cnt_r <= 8'h00;
         frame_r <= 80'h0;
         tx_sr_r <= 10'h3ff;
         bits_r <= 4'h0;
         bytes_r <= 4'h0;
         baud_r <= 9'h000;
         TXD_O <= 1'b1;
         TX_EN_O <= 1'b0;
         BUSY_O <= 1'b0;
         DONE_O <= 1'b0;
      end else if (CE_I) begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         frame_r <= frame_nxt;
         tx_sr_r <= tx_sr_nxt;
         bits_r <= bits_nxt;
         bytes_r <= bytes_nxt;
         baud_r <= baud_nxt;
         TXD_O <= txd_nxt;
         TX_EN_O <= tx_en_nxt;
         BUSY_O <= busy_nxt;
         DONE_O <= done_nxt;
      end
   end

endmodule

// ---- hdl/pos_framer_defs.vh ----
`ifndef POS_FRAMER_DEFS_VH
`define POS_FRAMER_DEFS_VH

// Clock and line rate
`define FR_CLK_HZ 40000000
`define FR_BAUD 115200

// Telegram layout
`define FR_BYTES_DUAL 4'hb
`define FR_BYTES_SINGLE 4'h3
`define FR_POS_USED 18
`define FR_FINE_USED 4

// Reflected Ethernet generator and preset
`define FR_CRC_POLY_REV 32'hedb88320
`define FR_CRC_PRESET 32'hffffffff

// Status nibble bit positions inside the second byte
`define FR_ST_EXTRAP 4
`define FR_ST_TAPE 5
`define FR_ST_NOEXTRAP 6
`define FR_ST_SINGLE 7

// Register offsets
`define FR_REG_CTRL 4'h0
`define FR_REG_STAT 4'h4

// Control fields and reset value
`define FR_CTRL_EN 0
`define FR_CTRL_SINGLE 1
`define FR_CTRL_RST 2'h1

// Diagnostic word counter slots
`define FR_AI_VMIN_A 8'hae
`define FR_AI_VMAX_A 8'haf
`define FR_AI_ERRS_A 8'hb4
`define FR_AI_OPT_A 8'hb6
`define FR_AI_VMIN_B 8'hee
`define FR_AI_VMAX_B 8'hef
`define FR_AI_ERRS_B 8'hf4
`define FR_AI_OPT_B 8'hf6

`endif

// ---- dv/fr_chk_assertions.sv ----
`timescale 1ns/100ps
module fr_chk (
   // Clock and reset
   input wire SYS_CLK_I,
   input wire RESETN_I,
   // Watched ports
   input wire SEND_I,
   input wire TXD_O,
   input wire TX_EN_O,
   input wire BUSY_O,
   input wire DONE_O
);
   // All properties share the device clock
   default clocking @(posedge SYS_CLK_I);
   endclocking
   default disable iff (!RESETN_I);
   property p_busy; BUSY_O == TX_EN_O; endproperty
   a_busy: assert property (p_busy) else $error("busy differs");
   property p_idle; !TX_EN_O |-> TXD_O; endproperty
   a_idle: assert property (p_idle) else $error("line low while idle");
   property p_start; $rose(TX_EN_O) |-> !TXD_O && $past(SEND_I); endproperty
   a_start: assert property (p_start) else $error("bad telegram start");
   property p_startlen; $rose(TX_EN_O) |=> (!TXD_O) [*3]; endproperty
   a_startlen: assert property (p_startlen) else $error("start bit short");
   property p_done; $fell(TX_EN_O) |-> DONE_O && TXD_O; endproperty
   a_done: assert property (p_done) else $error("no done at end");
   property p_pulse; DONE_O |=> !DONE_O; endproperty
   a_pulse: assert property (p_pulse) else $error("done too long");
   property p_stop; $fell(TX_EN_O) |-> $past(TXD_O); endproperty
   a_stop: assert property (p_stop) else $error("no stop bit");
   property p_nodone; TX_EN_O |-> !DONE_O; endproperty
   a_nodone: assert property (p_nodone) else $error("done while sending");
endmodule
bind pos_framer fr_chk i_fr_chk (.SYS_CLK_I(SYS_CLK_I), .RESETN_I(RESETN_I), .SEND_I(SEND_I),
   .TXD_O(TXD_O), .TX_EN_O(TX_EN_O), .BUSY_O(BUSY_O), .DONE_O(DONE_O));

// ---- dv/uart_sink.sv ----
`timescale 1ns/100ps
module uart_sink #(
   parameter BIT = 4
) (
   input wire clk_i,
   input wire rxd_i
);
   logic [7:0] q [$];
   logic [7:0] d;
   integer i;
   // Receives 8N1 frames, sampling mid bit, LSB first
   initial begin
      forever begin
         @(negedge rxd_i);
         repeat (BIT / 2) @(posedge clk_i);
         for (i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge clk_i);
            d[i] = rxd_i;
         end
         repeat (BIT) @(posedge clk_i);
         q.push_back(d);
      end
   end
endmodule

// ---- dv/safe_position_message_framer_bench.sv ----
`timescale 1ns/100ps
module safe_position_message_framer_bench;
   logic SYS_CLK_I = 0, RESETN_I = 0, SEND_I = 0, WR_I = 0, RD_I = 0, frc = 0, s;
   logic EXTRAP_I = 0, TAPE_BAD_I = 0, NOEXTRAP_I = 0, UNDERVOLT_I = 0;
   logic [19:0] POS_I = 0;
   logic [7:0] FINE_I = 0, c = 0;
   logic [3:0] ADDR_I = 0;
   logic [31:0] WDATA_I = 0, RDATA_O, r = 32'h7d98, x, y;
   logic [31:0] w [10] = '{default: 32'h0};
   logic [87:0] e;
   wire TXD_O, TX_EN_O, BUSY_O, DONE_O;
   int fail_count = 0, total_checks = 0, n;
   pos_framer #(.CLK_HZ(40000000), .BAUD(10000000)) i_pos_framer (.SYS_CLK_I(SYS_CLK_I),
      .RESETN_I(RESETN_I), .CE_I(1'b1), .SEND_I(SEND_I), .POS_I(POS_I), .FINE_I(FINE_I),
      .EXTRAP_I(EXTRAP_I), .TAPE_BAD_I(TAPE_BAD_I), .NOEXTRAP_I(NOEXTRAP_I),
      .UNDERVOLT_I(UNDERVOLT_I), .CODE_CRC_I(w[0]), .SERIAL_I(w[1]), .ERR_A_I(w[2]),
      .ERR_B_I(w[3]), .VMIN_A_I(w[8][31:16]), .VMAX_A_I(w[8][15:0]), .ERRS_A_I(w[4]),
      .UPTIME_A_I(w[5]), .VMIN_B_I(w[9][31:16]), .VMAX_B_I(w[9][15:0]), .ERRS_B_I(w[6]),
      .UPTIME_B_I(w[7]), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I),
      .RDATA_O(RDATA_O), .TXD_O(TXD_O), .TX_EN_O(TX_EN_O), .BUSY_O(BUSY_O), .DONE_O(DONE_O));
   uart_sink #(.BIT(4)) i_uart_sink (.clk_i(SYS_CLK_I), .rxd_i(TXD_O));
   // Free running 40 MHz clock
   initial forever #12.5 SYS_CLK_I = ~SYS_CLK_I;
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return v[0] ? (v >> 1) ^ 32'h80200003 : v >> 1;
   endfunction
   function automatic logic [31:0] crc(input logic [31:0] d);
      logic [31:0] k = 32'hffffffff;
      for (int i = 31; i >= 0; i--) k = (k >> 1) ^ ((k[0] ^ d[i]) ? 32'hedb88320 : 32'h0);
      return ~k;
   endfunction
   function automatic logic [15:0] info(input logic [7:0] q);
      logic [31:0] v = 32'h0;
      if (q < 8) v = w[q >> 1];
      if (q == 174 || q == 175) v = w[8];
      if (q >= 180 && q <= 183) v = w[4 + (q - 180) / 2];
      if (q == 238 || q == 239) v = w[9];
      if (q >= 244 && q <= 247) v = w[6 + (q - 244) / 2];
      return q[0] ? v[15:0] : v[31:16];
   endfunction
   task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      total_checks++;
      if (ex !== got) begin
         fail_count++;
         $display("unexpected %s: expected %h, seen %h", nm, ex, got);
      end
   endtask
   task wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge SYS_CLK_I);
      ADDR_I <= a;
      WDATA_I <= v;
      WR_I <= 1'b1;
      @(posedge SYS_CLK_I);
      WR_I <= 1'b0;
   endtask
   task rd(input logic [3:0] a, input logic [31:0] ex);
      @(posedge SYS_CLK_I);
      ADDR_I <= a;
      RD_I <= 1'b1;
      @(posedge SYS_CLK_I);
      RD_I <= 1'b0;
      #1 chk("read data", ex, RDATA_O);
   endtask
   // One telegram; request held two cycles so the second is refused
   task tel(input logic dual, input logic en);
      int k;
      @(posedge SYS_CLK_I);
      for (k = 0; k < 10; k++) begin
         r = lfsr(r);
         w[k] <= r;
      end
      {EXTRAP_I, TAPE_BAD_I, NOEXTRAP_I} <= r[2:0];
      POS_I <= r[27:8];
      FINE_I <= r[31:24];
      UNDERVOLT_I <= !dual;
      SEND_I <= 1'b1;
      @(posedge SYS_CLK_I);
      s = UNDERVOLT_I | frc;
      x = {c, {s, NOEXTRAP_I, TAPE_BAD_I, EXTRAP_I} ^ {4{c[0]}}, 2'b0, POS_I[17:0]};
      e = {x, crc(x), info(c), 4'h0, FINE_I[3:0]};
      @(posedge SYS_CLK_I);
      SEND_I <= 1'b0;
      k = 0;
      while (k < 600 && DONE_O !== 1'b1) begin
         @(posedge SYS_CLK_I);
         #1 k++;
      end
      chk("byte count", !en ? 0 : s ? 3 : 11, i_uart_sink.q.size());
      for (k = 0; k < i_uart_sink.q.size() && k < 11; k++)
         chk("telegram byte", e[87 - 8 * k -: 8], i_uart_sink.q[k]);
      if (i_uart_sink.q.size() == 11) begin
         x = {i_uart_sink.q[0], i_uart_sink.q[1], i_uart_sink.q[2], i_uart_sink.q[3]};
         y = {i_uart_sink.q[4], i_uart_sink.q[5], i_uart_sink.q[6], i_uart_sink.q[7]};
         chk("received checksum", crc(x), y);
         chk("masked position", POS_I[17:0], x[17:0]);
      end
      i_uart_sink.q.delete();
      $display("telegram %0d done", c);
      c++;
   endtask
   task give_verdict;
      $display("checks %0d, mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // Watchdog against a hang
   initial begin
      repeat (90000) @(posedge SYS_CLK_I);
      fail_count++;
      give_verdict;
   end
   // Main sequence
   initial begin
      repeat (16) @(posedge SYS_CLK_I);
      RESETN_I <= 1'b1;
      rd(4'h0, 32'h1);
      rd(4'h8, 32'h0);
      wr(4'h0, 32'h0);
      tel(1, 0);
      c--;
      wr(4'h0, 32'h3);
      frc = 1'b1;
      tel(1, 1);
      frc = 1'b0;
      wr(4'h0, 32'h1);
      for (n = 0; n < 258; n++)
         tel(c < 8 || (c >= 174 && c <= 183) || (c >= 238 && c <= 247) || r[6:4] == 3'h0, 1);
      rd(4'h4, {16'h0, c, 6'h0, UNDERVOLT_I, 1'b0});
      give_verdict;
   end
endmodule
